// File: src/intc_core.sv
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - FL match in 8-bit mode sets flag
// - Timer C wrap either way sets flag
// - Request two bit 0 reads zero
// - Selected wakeup edge sets wakeup flag
// - Wakeup flags cleared only by zero write
// - Edge select: 0 falling, 1 rising
// - Five request inputs plus eight wakeups
// - Group enable blocks all wakeup requests
// - All wakeups share vector nine
// - Pin edge select, flag only when selected
// - Pins use vectors 8..5, pin1 highest
// - Each pin has own enable bit
// - Peripheral flags, enables, vectors 19..10
// - Decoder ready edge-sensed, vector four
// - Highest priority chosen, others wait
// - Accept only while mask bit zero
// - Acceptance sets mask, vector presented
// - Requests gated by enable bits
// - Colliding request still taken later
// - Acceptance leaves flags set
// - Request one layout, bit 5 reads one
module intc_core
   import intc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   // Avalon-MM slave
   input  wire logic [4:0] avs_address_i,
   input  wire logic       avs_read_i,
   input  wire logic       avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0] avs_byteenable_i,
   output logic [31:0]     avs_readdata_o,
   output logic            avs_waitrequest_o,
   // External pins (asynchronous)
   input  wire logic [7:0] wakeup_pin_i,
   input  wire logic [4:1] external_request_pin_i,
   // Internal sources (same clock)
   input  wire logic       decoder_ready_i,
   input  wire logic       timer_a_ovf_i,
   input  wire logic       serial_done_i,
   input  wire logic [7:3] req_two_evt_i,
   input  wire logic       fl_8bit_mode_i,
   input  wire logic [7:0] timer_fl_counter_i,
   input  wire logic [7:0] timer_fl_compare_i,
   input  wire logic [7:0] timer_c_count_i,
   // CPU side
   input  wire logic       cpu_mask_i,
   input  wire logic       cpu_ack_i,
   output logic            irq_req_o,
   output logic [4:0]      irq_vector_o,
   output logic            mask_set_o
);
   import intc_pkg::*;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] req_one_r;          // request_register_one
   logic [7:0] req_two_r;          // request_register_two
   logic [7:0] wake_req_r;         // wakeup_request_flags
   logic [7:0] wake_edge_r;        // wakeup_edge_select
   logic [7:0] en_one_r;           // enable_register_one
   logic [7:0] en_two_r;           // enable_register_two
   logic [7:0] pin_edge_r;         // pin_edge_register
   logic [4:0] pin_fn_r;           // port_function_reg_three bits
   logic [7:0] wake_fn_r;          // port_function_reg_five bits
   logic [7:0] c_prev_r;           // Previous timer C count
   logic       rd_valid_r;         // Read answer stage
   logic [31:0] rdata_r;           // Read data register
   logic [4:0] vec_r;              // Registered vector
   logic       req_r;              // Registered request
   ack_state_t st_r;               // Acceptance state

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------
   logic [11:0] s1_r;              // First stage only
   logic [11:0] s2_r;              // Second stage
   logic [11:0] s3_r;              // Previous synced value
   logic        rdy_prev_r;        // Previous decoder ready
   wire  [11:0] pin_raw = {external_request_pin_i, wakeup_pin_i};

   // Two-flop synchroniser, then a history stage
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1_r <= 12'h000;
         s2_r <= 12'h000;
         s3_r <= 12'h000;
         rdy_prev_r <= 1'b0;
      end else begin
         s1_r <= pin_raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
         rdy_prev_r <= decoder_ready_i;
      end
   end

   // ----------------------------------------------------------------
   // Flag set sources
   // ----------------------------------------------------------------
   wire [11:0] rise_w = s2_r & ~s3_r;        // Rising edges
   wire [11:0] fall_w = ~s2_r & s3_r;        // Falling edges
   wire [7:0] wake_evt = wake_fn_r &
                         ((wake_edge_r & rise_w[7:0]) | (~wake_edge_r & fall_w[7:0]));
   // pin edge choice and function gate
   wire [4:1] pin_evt = pin_fn_r[4:1] &
                        ((pin_edge_r[4:1] & rise_w[11:8]) | (~pin_edge_r[4:1] & fall_w[11:8]));
   wire rdy_evt = pin_fn_r[0] & (pin_edge_r[0] ? (decoder_ready_i & ~rdy_prev_r)
                                              : (~decoder_ready_i & rdy_prev_r));
   wire fl_evt = fl_8bit_mode_i & (timer_fl_counter_i == timer_fl_compare_i);
   wire c_evt = ((c_prev_r == CNT_MAX) && (timer_c_count_i == CNT_MIN)) ||
                ((c_prev_r == CNT_MIN) && (timer_c_count_i == CNT_MAX));

   wire [7:0] set_one = {timer_a_ovf_i, serial_done_i, 1'b0, pin_evt, rdy_evt};
   wire [7:0] set_two = {req_two_evt_i, fl_evt, c_evt, 1'b0};

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Lane 0 write strobe, blocked during a read answer
   wire       wr    = avs_write_i & ~rd_valid_r & avs_byteenable_i[0];
   wire [7:0] wd    = avs_writedata_i[7:0];
   wire       wr_r1 = wr & (avs_address_i == ADDR_REQ_ONE);
   wire       wr_r2 = wr & (avs_address_i == ADDR_REQ_TWO);
   wire       wr_wk = wr & (avs_address_i == ADDR_WAKE_REQ);
   wire [7:0] clr_one = wr_r1 ? ~wd : 8'h00;
   wire [7:0] clr_two = wr_r2 ? ~wd : 8'h00;
   wire [7:0] clr_wk  = wr_wk ? ~wd : 8'h00;
   wire [7:0] req_one_nxt = ((req_one_r & ~clr_one) | set_one) | (8'h01 << BIT_RSV_ONE);
   wire [7:0] req_two_nxt = ((req_two_r & ~(clr_two & MASK_REQ_TWO)) | set_two) & MASK_REQ_TWO;
   wire [7:0] wake_req_nxt = (wake_req_r & ~clr_wk) | wake_evt;

   // Read multiplexer
   logic [7:0] rd_byte;
   always_comb begin
      unique case (avs_address_i)
         ADDR_REQ_ONE:   rd_byte = req_one_r;
         ADDR_REQ_TWO:   rd_byte = req_two_r;
         ADDR_WAKE_REQ:  rd_byte = wake_req_r;
         ADDR_WAKE_EDGE: rd_byte = wake_edge_r;
         ADDR_EN_ONE:    rd_byte = en_one_r;
         ADDR_EN_TWO:    rd_byte = en_two_r;
         ADDR_PIN_EDGE:  rd_byte = pin_edge_r;
         ADDR_PORT_FN:   rd_byte = {3'h0, pin_fn_r};
         default:        rd_byte = 8'h00; // Unmapped reads zero
      endcase
   end

   // Registers and flags
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         req_one_r   <= RST_REQ_ONE;
         req_two_r   <= RST_ZERO;
         wake_req_r  <= RST_ZERO;
         wake_edge_r <= RST_ZERO;
         en_one_r    <= RST_ZERO;
         en_two_r    <= RST_ZERO;
         pin_edge_r  <= RST_ZERO;
         pin_fn_r    <= 5'h00;
         wake_fn_r   <= RST_ZERO;
         c_prev_r    <= RST_ZERO;
      end else begin
         req_one_r  <= req_one_nxt;
         req_two_r  <= req_two_nxt;
         wake_req_r <= wake_req_nxt;
         c_prev_r   <= timer_c_count_i;
         if (wr && avs_address_i == ADDR_WAKE_EDGE) begin
            wake_edge_r <= wd;
         end
         if (wr && avs_address_i == ADDR_EN_ONE) begin
            en_one_r <= wd;
         end
         if (wr && avs_address_i == ADDR_EN_TWO) begin
            en_two_r <= wd;
         end
         if (wr && avs_address_i == ADDR_PIN_EDGE) begin
            pin_edge_r <= wd;
         end
         if (wr && avs_address_i == ADDR_PORT_FN) begin
            pin_fn_r <= wd[4:0];
         end
         // Wakeup function bits in second byte
         if (avs_write_i && !rd_valid_r && avs_byteenable_i[1] &&
             avs_address_i == ADDR_PORT_FN) begin
            wake_fn_r <= avs_writedata_i[15:8];
         end
      end
   end

   // Bus answer: writes in one cycle, reads in two
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rd_valid_r <= 1'b0;
         rdata_r    <= 32'h0000_0000;
      end else begin
         rd_valid_r <= avs_read_i & ~rd_valid_r;
         if (avs_read_i && !rd_valid_r) begin
            rdata_r <= (avs_address_i == ADDR_PORT_FN) ?
                       {16'h0000, wake_fn_r, rd_byte} : {24'h000000, rd_byte};
         end
      end
   end
   assign avs_waitrequest_o = avs_read_i & ~rd_valid_r;
   assign avs_readdata_o    = rdata_r;

   // ----------------------------------------------------------------
   // Priority selection
   // ----------------------------------------------------------------
   // per-source enables
   wire [7:0] act_one = req_one_r & en_one_r & ~(8'h01 << BIT_RSV_ONE);
   wire [7:0] act_two = req_two_r & en_two_r & MASK_REQ_TWO;
   wire       act_wk  = (|wake_req_r) & en_one_r[BIT_WAKE_GROUP];

   logic       sel_v;
   logic [4:0] sel_vec;
   always_comb begin
      sel_v   = 1'b1;
      sel_vec = VEC_READY;
      if (act_one[0]) begin
         sel_vec = VEC_READY;
      end else if (act_one[1]) begin
         sel_vec = VEC_PIN1;
      end else if (act_one[2]) begin
         sel_vec = VEC_PIN1 + 5'h01;
      end else if (act_one[3]) begin
         sel_vec = VEC_PIN1 + 5'h02;
      end else if (act_one[4]) begin
         sel_vec = VEC_PIN1 + 5'h03;
      end else if (act_wk) begin
         sel_vec = VEC_WAKE;
      end else if (act_one[BIT_SER_ONE]) begin
         sel_vec = VEC_SER;
      end else if (act_one[BIT_TA_OVF]) begin
         sel_vec = VEC_TA;
      end else if (act_two[1]) begin
         sel_vec = VEC_REQ2;
      end else if (act_two[2]) begin
         sel_vec = VEC_REQ2 + 5'h01;
      end else if (act_two[3]) begin
         sel_vec = VEC_REQ2 + 5'h02;
      end else if (act_two[4]) begin
         sel_vec = VEC_REQ2 + 5'h03;
      end else if (act_two[5]) begin
         sel_vec = VEC_REQ2 + 5'h04;
      end else if (act_two[6]) begin
         sel_vec = VEC_REQ2 + 5'h05;
      end else if (act_two[7]) begin
         sel_vec = VEC_REQ2 + 5'h06;
      end else begin
         sel_v = 1'b0;
      end
   end

   // Acceptance handshake with the CPU core
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         req_r <= 1'b0;
         vec_r <= 5'h00;
         st_r  <= ST_IDLE;
      end else begin
         unique case (st_r)
            ST_IDLE: begin
               req_r <= sel_v & ~cpu_mask_i;
               vec_r <= sel_vec;
               if (req_r && cpu_ack_i) begin
                  st_r  <= ST_ACCEPT;
                  req_r <= 1'b0;
               end
            end
            ST_ACCEPT: begin
               req_r <= 1'b0;
               st_r  <= ST_IDLE;
            end
         endcase
      end
   end
   assign irq_req_o    = req_r;
   assign irq_vector_o = vec_r;
   assign mask_set_o   = (st_r == ST_ACCEPT);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Request taken by the core while idle
   sequence s_accept;
      req_r && cpu_ack_i && st_r == ST_IDLE;
   endsequence
   // Mask pulse of exactly one cycle
   sequence s_mask_pulse;
      mask_set_o ##1 !mask_set_o;
   endsequence

   property p_rsv_two;
      @(posedge clk_i) disable iff (!nrst_i)
         req_two_r[BIT_RSV_TWO] == 1'b0;
   endproperty
   a_rsv_two: assert property (p_rsv_two) else $error("reserved bit set");
   property p_rsv_one;
      @(posedge clk_i) disable iff (!nrst_i)
         req_one_r[BIT_RSV_ONE] == 1'b1;
   endproperty
   a_rsv_one: assert property (p_rsv_one) else $error("reserved bit clear");
   property p_c_wrap;
      @(posedge clk_i) disable iff (!nrst_i)
         c_evt |=> req_two_r[BIT_C_WRAP];
   endproperty
   a_c_wrap: assert property (p_c_wrap) else $error("timer C flag missed");
   property p_fl;
      @(posedge clk_i) disable iff (!nrst_i)
         fl_evt |=> req_two_r[BIT_FL_MATCH];
   endproperty
   a_fl: assert property (p_fl) else $error("timer FL flag missed");
   property p_wk_hold;
      @(posedge clk_i) disable iff (!nrst_i)
         (wr_wk && wd[0] && wake_req_r[0]) |=> wake_req_r[0];
   endproperty
   a_wk_hold: assert property (p_wk_hold) else $error("flag lost on one write");
   property p_wk_clr;
      @(posedge clk_i) disable iff (!nrst_i)
         (wr_wk && !wd[7] && !wake_evt[7]) |=> !wake_req_r[7];
   endproperty
   a_wk_clr: assert property (p_wk_clr) else $error("flag kept after zero write");
   property p_set_wins;
      @(posedge clk_i) disable iff (!nrst_i)
         (wr_r1 && !wd[BIT_TA_OVF] && set_one[BIT_TA_OVF]) |=> req_one_r[BIT_TA_OVF];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("set lost to clear");
   property p_mask;
      @(posedge clk_i) disable iff (!nrst_i)
         (cpu_mask_i && st_r == ST_IDLE) |=> !req_r;
   endproperty
   a_mask: assert property (p_mask) else $error("request while masked");
   property p_accept;
      @(posedge clk_i) disable iff (!nrst_i)
         s_accept |=> s_mask_pulse;
   endproperty
   a_accept: assert property (p_accept) else $error("mask pulse missing");
   property p_keep;
      @(posedge clk_i) disable iff (!nrst_i)
         (req_r && cpu_ack_i && st_r == ST_IDLE && wake_req_r[0] && !wr_wk) |=> wake_req_r[0];
   endproperty
   a_keep: assert property (p_keep) else $error("flag cleared by accept");
   property p_wake_vec;
      @(posedge clk_i) disable iff (!nrst_i)
         (sel_v && act_wk && act_one[4:0] == 5'h00) |-> sel_vec == VEC_WAKE;
   endproperty
   a_wake_vec: assert property (p_wake_vec) else $error("wrong wakeup vector");
   property p_grp_off;
      @(posedge clk_i) disable iff (!nrst_i)
         !en_one_r[BIT_WAKE_GROUP] |-> !(sel_v && sel_vec == VEC_WAKE);
   endproperty
   a_grp_off: assert property (p_grp_off) else $error("wakeup chosen while off");
   property p_pin_order;
      @(posedge clk_i) disable iff (!nrst_i)
         (act_one[1] && !act_one[0]) |-> sel_vec == VEC_PIN1;
   endproperty
   a_pin_order: assert property (p_pin_order) else $error("pin one not first");

endmodule // intc_core
`default_nettype wire

// File: src/intc_pkg.sv
package intc_pkg;
   // ----------------------------------------------------------------
   // Register word addresses (byte address, one aligned word each)
   // ----------------------------------------------------------------
   localparam logic [4:0] ADDR_REQ_ONE   = 5'h00; // request_register_one
   localparam logic [4:0] ADDR_REQ_TWO   = 5'h04; // request_register_two
   localparam logic [4:0] ADDR_WAKE_REQ  = 5'h08; // wakeup_request_flags
   localparam logic [4:0] ADDR_WAKE_EDGE = 5'h0C; // wakeup_edge_select
   localparam logic [4:0] ADDR_EN_ONE    = 5'h10; // enable_register_one
   localparam logic [4:0] ADDR_EN_TWO    = 5'h14; // enable_register_two
   localparam logic [4:0] ADDR_PIN_EDGE  = 5'h18; // pin_edge_register
   localparam logic [4:0] ADDR_PORT_FN   = 5'h1C; // port functions + status
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BIT_TA_OVF     = 7; // Timer A flag in request one
   localparam int BIT_SER_ONE    = 6; // Serial link one flag
   localparam int BIT_RSV_ONE    = 5; // Reserved, reads one
   localparam int BIT_WAKE_GROUP = 5; // Wakeup group enable in enable one
   localparam int BIT_FL_MATCH   = 2; // Timer FL flag in request two
   localparam int BIT_C_WRAP     = 1; // Timer C flag in request two
   localparam int BIT_RSV_TWO    = 0; // Reserved, reads zero
   // ----------------------------------------------------------------
   // Reset values and masks
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_REQ_ONE  = 8'h20; // Bit 5 set
   localparam logic [7:0] RST_ZERO     = 8'h00; // Generic zero reset
   localparam logic [7:0] MASK_REQ_TWO = 8'hFE; // Bit 0 not writable
   localparam logic [7:0] CNT_MAX      = 8'hFF; // Counter top value
   localparam logic [7:0] CNT_MIN      = 8'h00; // Counter bottom value
   // ----------------------------------------------------------------
   // Vector numbers
   // ----------------------------------------------------------------
   localparam logic [4:0] VEC_WAKE  = 5'h09; // Shared wakeup vector
   localparam logic [4:0] VEC_PIN1  = 5'h05; // Pin 1 vector, 2..4 follow
   localparam logic [4:0] VEC_READY = 5'h04; // Decoder ready vector
   localparam logic [4:0] VEC_TA    = 5'h0B; // Timer A
   localparam logic [4:0] VEC_SER   = 5'h0A; // Serial link one
   localparam logic [4:0] VEC_REQ2  = 5'h0D; // Request two base, bits 1..7
   // Acceptance handshake states
   typedef enum logic [1:0] {ST_IDLE, ST_ACCEPT} ack_state_t;
endpackage

// File: verification/cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// CPU core: exception entry behaviour
// ----------------------------------------
module cpu_model (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   // Controller side
   input  wire logic       irq_req_i,
   input  wire logic [4:0] irq_vector_i,
   input  wire logic       mask_set_i,
   // Bench controls
   input  wire logic       unmask_i,
   input  wire logic       slow_i,
   // Mask, take, result
   output logic            cpu_mask_o,
   output logic            cpu_ack_o,
   output logic            taken_o,
   output logic [4:0]      taken_vec_o
);
   logic [2:0] wait_r; // Cycles of current instruction
   // Instruction finish, take, stacking
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cpu_mask_o  <= 1'h1; // Masked out of reset
         cpu_ack_o   <= 1'h0;
         taken_o     <= 1'h0;
         taken_vec_o <= 5'h00;
         wait_r      <= 3'h0;
      end else begin
         cpu_ack_o <= 1'h0;
         taken_o   <= 1'h0;
         if (mask_set_i) begin
            cpu_mask_o <= 1'h1;
            taken_o    <= 1'h1; // Handler starts
         end else if (unmask_i) begin
            cpu_mask_o <= 1'h0; // Return from handler
         end
         if (cpu_ack_o && irq_req_i) begin
            taken_vec_o <= irq_vector_i; // Vector fetched
         end else if (irq_req_i && !cpu_mask_o) begin
            if (wait_r >= (slow_i ? 3'h6 : 3'h0)) begin
               cpu_ack_o <= 1'h1;
               wait_r    <= 3'h0;
            end else begin
               wait_r <= wait_r + 3'h1; // Long instruction
            end
         end
      end
   end
endmodule // cpu_model
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import intc_pkg::*;
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic        clk = 1'h0, nrst = 1'h0;
   logic [4:0]  addr = 5'h00;
   logic        rd_en = 1'h0, wr_en = 1'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0]  be = 4'h0;
   logic [7:0]  wake = 8'hFF, e;
   logic [4:1]  ext = 4'hF;
   logic        ready = 1'h1, ta = 1'h0, ser = 1'h0;
   logic [7:3]  evt = 5'h00;
   logic        fl_mode = 1'h0, unmask = 1'h0, slow = 1'h0;
   logic [7:0]  fl_cnt = 8'h00, fl_cmp = 8'h00, c_cnt = 8'h80;
   logic        waitreq, mask, ack, irq, mask_set, taken;
   logic [4:0]  vec, taken_vec;
   logic [7:0]  exp_rd[$];   // Expected read bytes
   logic [4:0]  exp_vec[$];  // Expected vectors
   int          err_count = 0, samples_checked = 0, cycles = 0;
   always #4 clk = ~clk;
   intc_core intc_core_i (.clk_i(clk), .nrst_i(nrst), .avs_address_i(addr),
      .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
      .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
      .wakeup_pin_i(wake), .external_request_pin_i(ext), .decoder_ready_i(ready),
      .timer_a_ovf_i(ta), .serial_done_i(ser), .req_two_evt_i(evt),
      .fl_8bit_mode_i(fl_mode), .timer_fl_counter_i(fl_cnt),
      .timer_fl_compare_i(fl_cmp), .timer_c_count_i(c_cnt), .cpu_mask_i(mask),
      .cpu_ack_i(ack), .irq_req_o(irq), .irq_vector_o(vec), .mask_set_o(mask_set));
   cpu_model cpu_model_i (.clk_i(clk), .nrst_i(nrst), .irq_req_i(irq),
      .irq_vector_i(vec), .mask_set_i(mask_set), .unmask_i(unmask), .slow_i(slow),
      .cpu_mask_o(mask), .cpu_ack_o(ack), .taken_o(taken), .taken_vec_o(taken_vec));
   // ----------------------------------------
   // Compare and report tasks
   // ----------------------------------------
   task automatic cmp_rd(input logic [7:0] got);
      logic [7:0] want;
      want = exp_rd.size() ? exp_rd.pop_front() : 8'hXX;
      samples_checked++;
      if (got !== want) begin
         err_count++;
         $display("ERROR %0t read %h want %h", $time, got, want);
      end
   endtask
   task automatic cmp_vec(input logic [4:0] got);
      logic [4:0] want;
      want = exp_vec.size() ? exp_vec.pop_front() : 5'hXX;
      samples_checked++;
      if (got !== want) begin
         err_count++;
         $display("ERROR %0t vector %0d want %0d", $time, got, want);
      end
   endtask
   task automatic test_done();
      if (exp_rd.size() + exp_vec.size() != 0) err_count++; // Unseen results
      $display("checked %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Read data taken at the accepting edge
   always @(posedge clk) if (rd_en && waitreq === 1'h0) cmp_rd(rdata[7:0]);
   // Handler entry seen on the CPU side
   always @(posedge clk) if (taken === 1'h1) cmp_vec(taken_vec);
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         $display("ERROR %0t timeout", $time);
         test_done();
      end
   end
   // ----------------------------------------
   // Bus cycles and helpers
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic bus(input logic [4:0] a, input logic w, input logic [15:0] d);
      addr <= a;
      wr_en <= w;
      rd_en <= !w;
      wdata <= {16'h0000, d};
      be <= 4'h3;
      @(posedge clk);
      // Wait for the slave, however long
      while (waitreq !== 1'h0) begin
         @(posedge clk);
      end
      rd_en <= 1'h0;
      wr_en <= 1'h0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      bus(a, 1'h1, d);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] x);
      exp_rd.push_back(x);
      bus(a, 1'h0, 16'h0000);
   endtask
   task automatic pulse_unmask();
      unmask <= 1'h1;
      tick(1);
      unmask <= 1'h0;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(6));
      e = 8'($urandom());
      tick(5);
      nrst <= 1'h1;
      tick(1);
      rd(ADDR_REQ_ONE, RST_REQ_ONE);
      rd(ADDR_REQ_TWO, RST_ZERO);
      rd(ADDR_WAKE_EDGE, RST_ZERO);
      rd(5'h02, 8'h00); // Unmapped place reads zero
      wr(ADDR_PORT_FN, 16'hFF1F); // All pins to interrupt use
      $display("test reset done");
      ta <= 1'h1;
      ser <= 1'h1;
      evt <= 5'h1F;
      fl_cnt <= e;
      fl_cmp <= e;
      c_cnt <= CNT_MAX;
      tick(1);
      ta <= 1'h0;
      ser <= 1'h0;
      evt <= 5'h00;
      tick(2);
      rd(ADDR_REQ_TWO, 8'hF8);
      fl_mode <= 1'h1;
      c_cnt <= CNT_MIN;
      tick(1);
      fl_mode <= 1'h0;
      tick(2);
      rd(ADDR_REQ_TWO, 8'hFE);
      rd(ADDR_REQ_ONE, 8'hE0);
      wr(ADDR_REQ_TWO, 16'h00FD);
      rd(ADDR_REQ_TWO, 8'hFC);
      c_cnt <= CNT_MAX;
      tick(2);
      wr(ADDR_REQ_TWO, 16'h00FF);
      rd(ADDR_REQ_TWO, 8'hFE);
      wr(ADDR_REQ_TWO, 16'h00FD);
      $display("test timers done");
      wr(ADDR_WAKE_EDGE, {8'h00, e});
      rd(ADDR_WAKE_EDGE, e);
      wake <= ~e;
      tick(6);
      rd(ADDR_WAKE_REQ, 8'h00);
      wake <= e;
      tick(6);
      rd(ADDR_WAKE_REQ, 8'hFF);
      wr(ADDR_WAKE_REQ, 16'h00FF);
      rd(ADDR_WAKE_REQ, 8'hFF);
      wr(ADDR_WAKE_REQ, 16'h007F);
      rd(ADDR_WAKE_REQ, 8'h7F);
      $display("test wakeup done");
      ext <= 4'h0;
      ready <= 1'h0;
      tick(6);
      rd(ADDR_REQ_ONE, 8'hFF);
      pulse_unmask();
      tick(20); // Nothing enabled, nothing taken
      for (int i = 0; i < 14; i++) begin
         exp_vec.push_back(5'(i < 8 ? 4 + i : 6 + i));
         slow <= 1'($urandom());
         if (i == 0) wr(ADDR_EN_ONE, 16'h00FF);
         else pulse_unmask();
         for (int n = 0; n < 60 && exp_vec.size() > 0; n++) tick(1);
         if (i == 0) rd(ADDR_REQ_ONE, 8'hFF);
         if (i == 0) wr(ADDR_EN_TWO, 16'h00FE);
         tick(6); // masked, no entry
         wr(i == 5 ? ADDR_WAKE_REQ : (i < 8 ? ADDR_REQ_ONE : ADDR_REQ_TWO),
            i == 5 ? 16'h0000 : 16'h00FF ^ (16'h0001 << (i < 8 ? i : i - 6)));
      end
      tick(10);
      rd(ADDR_REQ_ONE, RST_REQ_ONE);
      rd(ADDR_REQ_TWO, RST_ZERO);
      $display("test priority done");
      // Still masked here: flags below stay pending
      wr(ADDR_PORT_FN, 16'hFF00); // Pins and ready deselected
      wr(ADDR_PIN_EDGE, 16'h001F);
      rd(ADDR_PIN_EDGE, 8'h1F);
      ext <= 4'hF;
      ready <= 1'h1;
      tick(6);
      rd(ADDR_REQ_ONE, RST_REQ_ONE);
      wr(ADDR_PORT_FN, 16'hFF1F);
      ext <= 4'h0;
      ready <= 1'h0;
      tick(6);
      rd(ADDR_REQ_ONE, RST_REQ_ONE);
      ext <= 4'hF;
      ready <= 1'h1;
      tick(6);
      rd(ADDR_REQ_ONE, 8'h3F);
      ta <= 1'h1;
      wr(ADDR_REQ_ONE, 16'h007F);
      ta <= 1'h0;
      rd(ADDR_REQ_ONE, 8'hBF);
      $display("test edges done");
      test_done();
   end
endmodule // testbench
`default_nettype wire
